// ==== dv/btu_branch_trace_tb_top.sv ====
// Self-checking bench of the branch trace unit.
// Assumes the probe model btu_probe and the package btu_pkg.
`define CHK(n, e, g) begin total_checks++; if ((e) !== (g)) begin fail_count++; \
    $display("wrong value %s expected %h seen %h", n, e, g); end end
module btu_branch_trace_tb_top;
    timeunit 1ns;
    timeprecision 100ps;
    logic clk, rst_b, trace_port_clock, br_valid, br_exc, exc_complete, core_stall;
    logic run_start, run_end, port_en, realtime_mode, rec_valid, stall_seen;
    logic trace_port_frame, trace_port_start;
    logic [31:0] br_src, br_dst, exc_pc, run_start_addr, run_end_addr, rec_src, rec_dst, prev;
    logic [15:0] br_dst_insn, rec_insn;
    logic [3:0] trace_port_data, rec_hdr, store_count;
    logic [2:0] store_rd_idx;
    logic [27:0] store_rd_src, store_rd_dst;
    logic [83:0] e;
    logic [83:0] expq[$];
    logic [55:0] hist[$];
    logic [31:0] msk[4] = '{32'hffff_ffff, 32'h0000_ffff, 32'h0000_00ff, 32'h0000_000f};
    int fail_count, total_checks;

    btu_branch_trace dut (.clk, .rst_b, .trace_port_clock, .br_valid, .br_src, .br_dst,
        .br_dst_insn, .br_exc, .exc_complete, .exc_pc, .core_stall, .run_start,
        .run_start_addr, .run_end, .run_end_addr, .port_en, .realtime_mode, .store_rd_idx,
        .store_rd_src, .store_rd_dst, .store_count, .trace_port_data, .trace_port_frame,
        .trace_port_start);
    btu_probe probe (.trace_port_clock, .trace_port_data, .trace_port_frame,
        .trace_port_start, .stop_mode(1'b0), .rec_valid, .rec_src, .rec_dst, .rec_insn,
        .rec_hdr);

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    function automatic logic [3:0] lvl(input logic [31:0] p, input logic [31:0] c);
        if (p[31:4] == c[31:4]) return 4'h3;
        if (p[31:8] == c[31:8]) return 4'h2;
        if (p[31:16] == c[31:16]) return 4'h1;
        return 4'h0;
    endfunction
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", total_checks, fail_count);
        if (fail_count == 0 && total_checks > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    // Offers one branch, held until accepted; notes the expected results
    task automatic branch(input logic [31:0] s, input logic [1:0] ex, input logic push);
        logic [31:0] eff;
        br_valid = 1'b1;
        br_src = s;
        br_dst = $urandom;
        br_dst_insn = 16'($urandom);
        br_exc = ex[1];
        exc_complete = ex[0];
        exc_pc = s - 32'h0000_0010;
        eff = (ex == 2'b11) ? exc_pc + 32'h0000_0002 : s;
        #1;
        while (core_stall !== 1'b0) begin
            stall_seen = 1'b1;
            @(negedge clk);
            #1;
        end
        hist.push_front({eff[27:0], br_dst[27:0]});
        if (push) expq.push_back({lvl(prev, eff), eff, br_dst, br_dst_insn});
        prev = eff;
        @(negedge clk);
    endtask
    task automatic rd(input int i);
        store_rd_idx = 3'(i);
        @(posedge clk);
        @(negedge clk);
        `CHK("store src", hist[i][55:28], store_rd_src)
        `CHK("store dst", hist[i][27:0], store_rd_dst)
    endtask
    task automatic drain();
        for (int i = 0; i < 3000 && expq.size() != 0; i++) @(negedge clk);
        `CHK("pending records", 0, expq.size())
    endtask

    // ------------------------------------------------------------
    // Record checker
    // ------------------------------------------------------------
    always @(posedge trace_port_clock) begin
        if (rec_valid === 1'b1) begin
            if (expq.size() == 0) `CHK("extra record", 1'b0, 1'b1)
            else begin
                e = expq.pop_front();
                `CHK("hdr", e[83:80], rec_hdr)
                `CHK("src", e[79:48], rec_src)
                `CHK("dst", e[47:16], rec_dst)
                `CHK("insn", e[15:0], rec_insn)
            end
        end
    end

    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    initial begin
        #100000;
        fail_count++;
        end_of_test();
    end
    initial begin
        void'($urandom(32'h5e4a_4321));
        {rst_b, br_valid, br_exc, exc_complete, run_start, run_end, port_en} = '0;
        {realtime_mode, stall_seen, store_rd_idx, prev} = '0;
        {br_src, br_dst, exc_pc, br_dst_insn, run_start_addr, run_end_addr} = '0;
        repeat (16) @(negedge clk);
        rst_b = 1'b1;
        repeat (3) @(negedge clk);
        run_end = 1'b1;
        run_end_addr = $urandom;
        @(negedge clk);
        run_end = 1'b0;
        run_start = 1'b1;
        run_start_addr = $urandom;
        @(negedge clk);
        run_start = 1'b0;
        hist.push_front({run_end_addr[27:0], run_start_addr[27:0]});
        `CHK("count", 4'h1, store_count)
        rd(0);
        $display("test run entry done");
        port_en = 1'b1;
        for (int i = 0; i < 9; i++) branch(prev ^ ((32'($urandom) | 32'h8000_0000) & msk[i % 4]),
            {i >= 7, i == 8}, 1'b1);
        br_valid = 1'b0;
        `CHK("stall", 1'b1, stall_seen)
        drain();
        `CHK("count", 4'h8, store_count)
        for (int i = 0; i < 8; i++) rd(i);
        $display("test lossless done");
        realtime_mode = 1'b1;
        stall_seen = 1'b0;
        branch(prev ^ 32'h8000_0000, 2'b00, 1'b0);
        branch(prev ^ 32'h8000_0000, 2'b00, 1'b1);
        br_valid = 1'b0;
        `CHK("stall", 1'b0, stall_seen)
        drain();
        $display("test realtime done");
        end_of_test();
    end
endmodule

// ==== dv/btu_probe.sv ====
// Behavioural trace probe: makes the trace clock and captures records.
// Assumes each record is framed by frame and start, nibbles LSB first.
module btu_probe #(
    parameter int BUF = 64
) (
    // Link
    output logic trace_port_clock,
    input wire logic [3:0] trace_port_data,
    input wire logic trace_port_frame,
    input wire logic trace_port_start,
    // Policy and captured record
    input wire logic stop_mode,
    output logic rec_valid,
    output logic [31:0] rec_src,
    output logic [31:0] rec_dst,
    output logic [15:0] rec_insn,
    output logic [3:0] rec_hdr
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [83:0] v;
    logic [31:0] last;
    logic [31:0] m;
    int cnt;
    int ns;
    int held;
    initial begin
        {cnt, held, last, rec_valid} = '0;
        trace_port_clock = 1'b0;
        #7;
        forever #16 trace_port_clock = ~trace_port_clock;
    end
    always @(posedge trace_port_clock) begin
        rec_valid <= 1'b0;
        if (trace_port_frame) begin
            if (trace_port_start) cnt = 0;
            if (cnt < 21) v[cnt*4 +: 4] = trace_port_data;
            cnt++;
        end else if (cnt > 0) begin
            ns = (v[3:0] == 4'h0) ? 8 : (v[3:0] == 4'h1) ? 5 : (v[3:0] == 4'h2) ? 3 : 2;
            m = 32'((64'h1 << (ns * 4)) - 64'h1);
            if (cnt == 13 + ns && !(stop_mode && held >= BUF)) begin
                last = (last & ~m) | (32'(v >> 4) & m);
                held = (held < BUF) ? held + 1 : BUF;
                rec_src <= last;
                rec_dst <= 32'(v >> (4 + ns * 4));
                rec_insn <= 16'(v >> (36 + ns * 4));
                rec_hdr <= v[3:0];
                rec_valid <= 1'b1;
            end
            cnt = 0;
        end
    end
endmodule

// ==== pkg/btu_pkg.sv ====
// Shared constants and types of the branch trace unit.
// Assumes a 32-bit core address space and a 4-bit trace data port.
package btu_pkg;

    // ------------------------------------------------------------
    // Widths
    // ------------------------------------------------------------
    localparam int ADDR_W = 32;
    localparam int STORE_W = 28;
    localparam int STORE_DEPTH = 8;
    localparam int INSN_W = 16;
    localparam int NIB_W = 4;
    localparam int FRAME_W = 84;
    localparam int LEN_W = 5;

    // ------------------------------------------------------------
    // Source compression: upper bits compared against last source
    // ------------------------------------------------------------
    localparam int MATCH_5 = 28;
    localparam int MATCH_9 = 24;
    localparam int MATCH_17 = 16;
    localparam logic [3:0] HDR_FULL = 4'h0;
    localparam logic [3:0] HDR_17 = 4'h1;
    localparam logic [3:0] HDR_9 = 4'h2;
    localparam logic [3:0] HDR_5 = 4'h3;
    localparam logic [3:0] NIBS_FULL = 4'h8;
    localparam logic [3:0] NIBS_17 = 4'h5;
    localparam logic [3:0] NIBS_9 = 4'h3;
    localparam logic [3:0] NIBS_5 = 4'h2;
    // Header, destination and instruction nibbles
    localparam logic [LEN_W-1:0] FIXED_NIBS = 5'h0d;

    // ------------------------------------------------------------
    // Misc
    // ------------------------------------------------------------
    localparam logic [ADDR_W-1:0] INSN_BYTES = 32'h0000_0002;

    typedef logic [STORE_W-1:0] btu_saddr_t;
    typedef logic [FRAME_W-1:0] btu_frame_t;
    typedef logic [LEN_W-1:0] btu_len_t;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b01,
        ST_SHIFT = 2'b10
    } btu_link_state_t;

endpackage

// ==== rtl/btu_branch_trace.sv ====
// Branch trace unit: internal branch history and a nibble trace port.
// Assumes branch events arrive on clk; the probe runs trace_port_clock
// whenever the port is enabled.
// Summary of operation
// - Store keeps the eight newest taken branches.
// - Stored addresses drop the upper four bits.
// - Run start logs last end to start.
// - Port record: source, destination, destination instruction.
// - Realtime: newer branch abandons record, no stall.
// - Lossless: stall core until record sent.
// - Port source sent relative to previous source.
// - Send 20, 12 or 8 low bits, or all 32 bits when no upper bits match.
// - Completion exception logs the following instruction address.
module btu_branch_trace #(
    parameter int DEPTH = btu_pkg::STORE_DEPTH
) (
    // Clocks and reset
    input wire logic clk,
    input wire logic rst_b,
    input wire logic trace_port_clock,
    // Branch events from the core
    input wire logic br_valid,
    input wire logic [btu_pkg::ADDR_W-1:0] br_src,
    input wire logic [btu_pkg::ADDR_W-1:0] br_dst,
    input wire logic [btu_pkg::INSN_W-1:0] br_dst_insn,
    input wire logic br_exc,
    input wire logic exc_complete,
    input wire logic [btu_pkg::ADDR_W-1:0] exc_pc,
    output logic core_stall,
    // Run control
    input wire logic run_start,
    input wire logic [btu_pkg::ADDR_W-1:0] run_start_addr,
    input wire logic run_end,
    input wire logic [btu_pkg::ADDR_W-1:0] run_end_addr,
    // Trace configuration
    input wire logic port_en,
    input wire logic realtime_mode,
    // Internal store read, index 0 is the newest
    input wire logic [$clog2(DEPTH)-1:0] store_rd_idx,
    output logic [btu_pkg::STORE_W-1:0] store_rd_src,
    output logic [btu_pkg::STORE_W-1:0] store_rd_dst,
    output logic [$clog2(DEPTH):0] store_count,
    // Trace output port
    output logic [btu_pkg::NIB_W-1:0] trace_port_data,
    output logic trace_port_frame,
    output logic trace_port_start
);

    localparam int PTR_W = $clog2(DEPTH);
    localparam int SW = btu_pkg::STORE_W;
    localparam int AW = btu_pkg::ADDR_W;

    if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_bad_depth
        $error("DEPTH must be a power of two of at least 2");
    end

    // ------------------------------------------------------------
    // Reset release
    // ------------------------------------------------------------
    logic rst_s1;
    logic core_rst_b;

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            rst_s1 <= 1'b0;
            core_rst_b <= 1'b0;
        end else begin
            rst_s1 <= 1'b1;
            core_rst_b <= rst_s1;
        end
    end

    // ------------------------------------------------------------
    // Source compression level
    // ------------------------------------------------------------
    function automatic logic [7:0] btu_src_level(
        input logic [AW-1:0] a,
        input logic [AW-1:0] b
    );
        if ((a >> (AW - btu_pkg::MATCH_5)) == (b >> (AW - btu_pkg::MATCH_5))) begin
            btu_src_level = {btu_pkg::HDR_5, btu_pkg::NIBS_5};
        end else if ((a >> (AW - btu_pkg::MATCH_9)) == (b >> (AW - btu_pkg::MATCH_9))) begin
            btu_src_level = {btu_pkg::HDR_9, btu_pkg::NIBS_9};
        end else if ((a >> (AW - btu_pkg::MATCH_17)) == (b >> (AW - btu_pkg::MATCH_17))) begin
            btu_src_level = {btu_pkg::HDR_17, btu_pkg::NIBS_17};
        end else begin
            btu_src_level = {btu_pkg::HDR_FULL, btu_pkg::NIBS_FULL};
        end
    endfunction

    // ------------------------------------------------------------
    // Branch acceptance and internal store
    // ------------------------------------------------------------
    logic [2*SW-1:0] mem [DEPTH];
    logic [PTR_W-1:0] wr_ptr;
    logic [PTR_W-1:0] next_wr_ptr;
    logic [PTR_W:0] next_count;
    logic [AW-1:0] last_end;
    logic [AW-1:0] next_last_end;
    logic [SW-1:0] next_rd_src;
    logic [SW-1:0] next_rd_dst;
    logic [2*SW-1:0] store_wdata;
    logic [2*SW-1:0] newest;
    logic [AW-1:0] eff_src;
    logic acc_br;
    logic store_we;
    logic busy;
    logic pend_v;

    // Completion-type exception points past the faulting instruction
    assign eff_src = (br_exc && exc_complete) ? exc_pc + btu_pkg::INSN_BYTES : br_src;
    // Lossless mode holds the core while a record is still going out
    assign core_stall = !realtime_mode && port_en && br_valid && (busy || pend_v);
    assign acc_br = br_valid && !core_stall;
    assign store_we = run_start || acc_br;
    assign newest = mem[wr_ptr - 1'b1];

    always_comb begin
        next_wr_ptr = wr_ptr;
        next_count = store_count;
        next_last_end = last_end;
        // Upper address bits are not kept
        if (run_start) begin
            store_wdata = {btu_pkg::btu_saddr_t'(last_end),
                           btu_pkg::btu_saddr_t'(run_start_addr)};
        end else begin
            store_wdata = {btu_pkg::btu_saddr_t'(eff_src),
                           btu_pkg::btu_saddr_t'(br_dst)};
        end
        if (store_we) begin
            // Ring of the newest entries, oldest overwritten
            next_wr_ptr = wr_ptr + 1'b1;
            if (store_count != (PTR_W + 1)'(DEPTH)) begin
                next_count = store_count + 1'b1;
            end
        end
        if (run_end) begin
            next_last_end = run_end_addr;
        end
        {next_rd_src, next_rd_dst} = mem[wr_ptr - 1'b1 - store_rd_idx];
    end

    always_ff @(posedge clk) begin
        if (store_we) begin
            mem[wr_ptr] <= store_wdata;
        end
    end

    always_ff @(posedge clk or negedge core_rst_b) begin
        if (!core_rst_b) begin
            wr_ptr <= '0;
            store_count <= '0;
            last_end <= '0;
            store_rd_src <= '0;
            store_rd_dst <= '0;
        end else begin
            wr_ptr <= next_wr_ptr;
            store_count <= next_count;
            last_end <= next_last_end;
            store_rd_src <= next_rd_src;
            store_rd_dst <= next_rd_dst;
        end
    end

    // ------------------------------------------------------------
    // Record build and hand-off to the link domain
    // ------------------------------------------------------------
    logic req;
    logic next_req;
    logic ack;
    logic ack_s1;
    logic ack_s2;
    logic rt_q;
    logic next_pend_v;
    logic launch;
    logic take_new;
    logic [AW-1:0] pend_src;
    logic [AW-1:0] pend_dst;
    logic [btu_pkg::INSN_W-1:0] pend_insn;
    logic [AW-1:0] next_pend_src;
    logic [AW-1:0] next_pend_dst;
    logic [btu_pkg::INSN_W-1:0] next_pend_insn;
    logic [AW-1:0] cand_src;
    logic [AW-1:0] cand_dst;
    logic [btu_pkg::INSN_W-1:0] cand_insn;
    logic [AW-1:0] prev_src;
    logic [AW-1:0] next_prev_src;
    logic [AW-1:0] src_mask;
    logic [7:0] lvl;
    btu_pkg::btu_frame_t rec_frame;
    btu_pkg::btu_frame_t next_rec_frame;
    btu_pkg::btu_len_t rec_len;
    btu_pkg::btu_len_t next_rec_len;

    assign busy = req != ack_s2;
    assign take_new = acc_br && port_en;
    assign launch = port_en && !busy && (take_new || pend_v);
    assign cand_src = take_new ? eff_src : pend_src;
    assign cand_dst = take_new ? br_dst : pend_dst;
    assign cand_insn = take_new ? br_dst_insn : pend_insn;
    assign lvl = btu_src_level(cand_src, prev_src);
    assign src_mask = {AW{1'b1}} >> ((btu_pkg::NIBS_FULL - lvl[3:0]) * btu_pkg::NIB_W);

    always_comb begin
        next_req = req;
        next_pend_v = pend_v;
        next_pend_src = pend_src;
        next_pend_dst = pend_dst;
        next_pend_insn = pend_insn;
        next_prev_src = prev_src;
        next_rec_frame = rec_frame;
        next_rec_len = rec_len;
        if (launch) begin
            // Header, source low bits, destination, instruction word
            next_rec_frame = (btu_pkg::btu_frame_t'({cand_insn, cand_dst})
                              << ((lvl[3:0] + 1) * btu_pkg::NIB_W))
                           | (btu_pkg::btu_frame_t'(cand_src & src_mask) << btu_pkg::NIB_W)
                           | btu_pkg::btu_frame_t'(lvl[7:4]);
            next_rec_len = btu_pkg::FIXED_NIBS + btu_pkg::btu_len_t'(lvl[3:0]);
            next_prev_src = cand_src;
            next_req = !req;
            // A newer branch supersedes a waiting one
            next_pend_v = 1'b0;
        end else if (take_new) begin
            next_pend_v = 1'b1;
            next_pend_src = eff_src;
            next_pend_dst = br_dst;
            next_pend_insn = br_dst_insn;
        end
        if (!port_en) begin
            next_pend_v = 1'b0;
        end
    end

    always_ff @(posedge clk or negedge core_rst_b) begin
        if (!core_rst_b) begin
            req <= 1'b0;
            pend_v <= 1'b0;
            pend_src <= '0;
            pend_dst <= '0;
            pend_insn <= '0;
            prev_src <= '0;
            rec_frame <= '0;
            rec_len <= '0;
            rt_q <= 1'b0;
            ack_s1 <= 1'b0;
            ack_s2 <= 1'b0;
        end else begin
            req <= next_req;
            pend_v <= next_pend_v;
            pend_src <= next_pend_src;
            pend_dst <= next_pend_dst;
            pend_insn <= next_pend_insn;
            prev_src <= next_prev_src;
            rec_frame <= next_rec_frame;
            rec_len <= next_rec_len;
            rt_q <= realtime_mode;
            ack_s1 <= ack;
            ack_s2 <= ack_s1;
        end
    end

    btu_link_tx u_link_tx (
        .trace_port_clock(trace_port_clock),
        .rst_b(rst_b),
        .req(req),
        .realtime_mode(rt_q),
        .rec_frame(rec_frame),
        .rec_len(rec_len),
        .ack(ack),
        .trace_port_data(trace_port_data),
        .trace_port_frame(trace_port_frame),
        .trace_port_start(trace_port_start)
    );

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    default clocking @(posedge clk); endclocking
    default disable iff (!core_rst_b);

    chk_store_fill: assert property (
        store_we && store_count < (PTR_W + 1)'(DEPTH) |=> store_count == $past(store_count) + 1'b1)
        else $error("store count did not advance");

    chk_store_full: assert property (
        store_count == (PTR_W + 1)'(DEPTH) |=> store_count == (PTR_W + 1)'(DEPTH))
        else $error("store count left full");

    chk_store_trunc: assert property (
        store_we && !run_start |=> newest == {btu_pkg::btu_saddr_t'($past(eff_src)),
                                              btu_pkg::btu_saddr_t'($past(br_dst))})
        else $error("branch entry not stored truncated");

    chk_run_entry: assert property (
        run_start |=> newest == {btu_pkg::btu_saddr_t'($past(last_end)),
                                 btu_pkg::btu_saddr_t'($past(run_start_addr))})
        else $error("run start entry wrong");

    chk_rt_nostall: assert property (
        realtime_mode |-> !core_stall)
        else $error("realtime mode stalled the core");

    chk_lossless_stall: assert property (
        !realtime_mode && port_en && acc_br ##1 !realtime_mode && port_en && br_valid
            |-> core_stall)
        else $error("core not stalled while record in flight");

    chk_src_delta: assert property (
        launch |=> prev_src == $past(cand_src) && req != $past(req))
        else $error("previous source not tracked");

    chk_short_level: assert property (
        launch && cand_src[AW-1:AW-btu_pkg::MATCH_5] == prev_src[AW-1:AW-btu_pkg::MATCH_5]
            |=> rec_len == btu_pkg::FIXED_NIBS + btu_pkg::btu_len_t'(btu_pkg::NIBS_5)
                && rec_frame[btu_pkg::NIB_W-1:0] == btu_pkg::HDR_5)
        else $error("five-bit compression not chosen");

    chk_exc_addr: assert property (
        acc_br && !run_start && br_exc && exc_complete
            |=> newest[2*SW-1:SW] == btu_pkg::btu_saddr_t'($past(exc_pc) + btu_pkg::INSN_BYTES))
        else $error("completion exception address wrong");

endmodule

// ==== rtl/btu_link_tx.sv ====
// Trace port serializer on the probe's trace port clock.
// Assumes rec_frame and rec_len stay stable while req differs from ack.
module btu_link_tx (
    // Clock and reset
    input wire logic trace_port_clock,
    input wire logic rst_b,
    // Record handshake from the core domain
    input wire logic req,
    input wire logic realtime_mode,
    input wire logic [btu_pkg::FRAME_W-1:0] rec_frame,
    input wire logic [btu_pkg::LEN_W-1:0] rec_len,
    output logic ack,
    // Trace pins
    output logic [btu_pkg::NIB_W-1:0] trace_port_data,
    output logic trace_port_frame,
    output logic trace_port_start
);

    // ------------------------------------------------------------
    // Reset release and synchronisers
    // ------------------------------------------------------------
    logic lrst_s1;
    logic link_rst_b;
    logic req_s1;
    logic req_s2;
    logic rt_s1;
    logic rt_s2;

    always_ff @(posedge trace_port_clock or negedge rst_b) begin
        if (!rst_b) begin
            lrst_s1 <= 1'b0;
            link_rst_b <= 1'b0;
        end else begin
            lrst_s1 <= 1'b1;
            link_rst_b <= lrst_s1;
        end
    end

    always_ff @(posedge trace_port_clock or negedge link_rst_b) begin
        if (!link_rst_b) begin
            req_s1 <= 1'b0;
            req_s2 <= 1'b0;
            rt_s1 <= 1'b0;
            rt_s2 <= 1'b0;
        end else begin
            req_s1 <= req;
            req_s2 <= req_s1;
            rt_s1 <= realtime_mode;
            rt_s2 <= rt_s1;
        end
    end

    // ------------------------------------------------------------
    // Shifter
    // ------------------------------------------------------------
    btu_pkg::btu_link_state_t state;
    btu_pkg::btu_link_state_t next_state;
    btu_pkg::btu_frame_t sh;
    btu_pkg::btu_frame_t next_sh;
    btu_pkg::btu_len_t cnt;
    btu_pkg::btu_len_t next_cnt;
    logic seen;
    logic next_seen;
    logic next_ack;
    logic [btu_pkg::NIB_W-1:0] next_data;
    logic next_frame;
    logic next_start;
    logic new_rec;
    logic load;

    assign new_rec = req_s2 != seen;
    // Realtime drops the record in flight for the newer one
    assign load = new_rec && (state == btu_pkg::ST_IDLE || rt_s2);

    always_comb begin
        next_state = state;
        next_sh = sh;
        next_cnt = cnt;
        next_seen = seen;
        next_ack = ack;
        next_data = '0;
        next_frame = 1'b0;
        next_start = 1'b0;
        if (load) begin
            // Header nibble goes out first
            next_data = rec_frame[btu_pkg::NIB_W-1:0];
            next_frame = 1'b1;
            next_start = 1'b1;
            next_sh = rec_frame >> btu_pkg::NIB_W;
            next_cnt = rec_len - 1'b1;
            next_seen = req_s2;
            next_state = btu_pkg::ST_SHIFT;
            if (rt_s2) begin
                next_ack = req_s2;
            end
        end else begin
            case (state)
                btu_pkg::ST_SHIFT: begin
                    next_data = sh[btu_pkg::NIB_W-1:0];
                    next_frame = 1'b1;
                    next_sh = sh >> btu_pkg::NIB_W;
                    next_cnt = cnt - 1'b1;
                    if (cnt == btu_len_one()) begin
                        // Lossless mode releases the core only here
                        next_ack = seen;
                        next_state = btu_pkg::ST_IDLE;
                    end
                end
                btu_pkg::ST_IDLE: next_state = btu_pkg::ST_IDLE;
                default: next_state = btu_pkg::ST_IDLE;
            endcase
        end
    end

    function automatic btu_pkg::btu_len_t btu_len_one();
        btu_len_one = btu_pkg::btu_len_t'(1);
    endfunction

    always_ff @(posedge trace_port_clock or negedge link_rst_b) begin
        if (!link_rst_b) begin
            state <= btu_pkg::ST_IDLE;
            sh <= '0;
            cnt <= '0;
            seen <= 1'b0;
            ack <= 1'b0;
            trace_port_data <= '0;
            trace_port_frame <= 1'b0;
            trace_port_start <= 1'b0;
        end else begin
            state <= next_state;
            sh <= next_sh;
            cnt <= next_cnt;
            seen <= next_seen;
            ack <= next_ack;
            trace_port_data <= next_data;
            trace_port_frame <= next_frame;
            trace_port_start <= next_start;
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    default clocking @(posedge trace_port_clock); endclocking
    default disable iff (!link_rst_b);

    chk_nibble_head: assert property (
        load |=> trace_port_start && trace_port_frame
            && trace_port_data == $past(rec_frame[btu_pkg::NIB_W-1:0]))
        else $error("record header nibble not driven");

    chk_abandon_old: assert property (
        state == btu_pkg::ST_SHIFT && new_rec && rt_s2 |=> trace_port_start ##1 !trace_port_start)
        else $error("realtime record not abandoned");

    chk_lossless_hold: assert property (
        state == btu_pkg::ST_SHIFT && !rt_s2 && ack != seen && cnt > btu_len_one()
            |=> ack == $past(ack) && trace_port_frame)
        else $error("lossless record released early");

endmodule
